// *** shared/mg_pkg.sv ***
/*
 Constants for the management command responder: command codes,
 field positions, reset values and link framing counts.
 Assumes every user refers to names as mg_pkg::name.
*/
`default_nettype none
package mg_pkg;
   // Command codes
   localparam logic [7:0] CMD_CLEAR = 8'h03;
   localparam logic [7:0] CMD_CAP = 8'h19;
   localparam logic [7:0] CMD_FSB = 8'h78;
   localparam logic [7:0] CMD_FSW = 8'h79;
   localparam logic [7:0] CMD_TMP1 = 8'h8d;
   localparam logic [7:0] CMD_TMP2 = 8'h8e;
   localparam logic [7:0] CMD_PROTO = 8'h98;
   localparam logic [7:0] CMD_MAKER = 8'h99;
   localparam logic [7:0] CMD_MODEL = 8'h9a;
   localparam logic [7:0] CMD_MVER = 8'h9b;
   localparam logic [7:0] CMD_PG_FIRST = 8'hb0;
   localparam logic [7:0] CMD_PG_LAST = 8'hbf;
   localparam logic [7:0] CMD_CRC = 8'hd1;
   localparam logic [7:0] CMD_RDLEN = 8'hd2;
   localparam logic [7:0] CMD_OFS = 8'hd3;
   // Operation byte, first byte of every frame
   localparam logic [7:0] OP_READ = 8'h01;
   // Capability fields
   localparam logic [1:0] CAP_SPEED = 2'h1;
   localparam logic [7:0] CAP_RESET = 8'h20;
   // Status word: only the comms/memory/logic bit exists
   localparam int FSW_CML_BIT = 1;
   // Revision and register reset values
   localparam logic [7:0] PROTO_RESET = 8'h11;
   localparam logic [7:0] RDLEN_RESET = 8'h08;
   localparam logic [15:0] OFS_RESET = 16'h0000;
   // Temperature word layout
   localparam int TMP_EXP_LSB = 11;
   // Memory pages
   localparam logic [3:0] PG_WR_MIN = 4'h4;
   localparam int PG_AW = 5;
   localparam int NVM_WORDS = 512;
   // Link byte framing: lead clocks, then eight data clocks
   localparam logic [3:0] LEAD_CLKS = 4'h2;
   localparam logic [3:0] LAST_CLK = 4'h9;
   localparam logic [7:0] IDLE_BYTE = 8'hff;
endpackage
`default_nettype wire

// *** shared/mg_xfer_if.sv ***
/*
 Byte exchange between the link shifter and the command core.
 Assumes rx_data is stable while rx_tgl crosses, and tx_data and
 tx_drive are stable while tx_tgl crosses.
*/
`default_nettype none
interface mg_xfer_if;
   logic [7:0] rx_data; // Last byte from host
   logic rx_tgl; // Flips per received byte
   logic [7:0] tx_data; // Next byte for host
   logic tx_drive; // Next byte is driven
   logic tx_tgl; // Flips per answer
   modport link (output rx_data, rx_tgl, input tx_data, tx_drive, tx_tgl);
   modport core (input rx_data, rx_tgl, output tx_data, tx_drive, tx_tgl);
endinterface
`default_nettype wire

// *** rtl/mg_link_shifter.sv ***
/*
 Link shifter on the host's serial clock: ten clocks a byte, two lead
 clocks then eight data clocks, most significant bit first.
 Assumes the clock only runs while i_sel_n is low.
*/
`default_nettype none
module mg_link_shifter (
   input wire logic i_link_clk,
   input wire logic i_rst,
   input wire logic i_sel_n,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   mg_xfer_if.link xfer
);
   logic frame_rst; // Ends byte state with the frame
   logic [3:0] cnt_q; // Clock within byte
   logic [7:0] rx_sh_q; // Receive shifter
   logic [7:0] tx_sh_q; // Transmit shifter
   logic drive_q; // Pin is driven
   logic ack_s1_q; // Answer toggle, stage one
   logic ack_s2_q; // Answer toggle, stage two
   logic ack_seen_q; // Last answer used
   logic [7:0] rx_data_q;
   logic rx_tgl_q;

   // The clock stops after a frame, so the select line resets
   assign frame_rst = i_rst | i_sel_n;

   // Byte counter, shifters and drive
   always_ff @(posedge i_link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_q <= 4'h0;
         rx_sh_q <= 8'h00;
         tx_sh_q <= mg_pkg::IDLE_BYTE;
         drive_q <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == mg_pkg::LAST_CLK) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q >= mg_pkg::LEAD_CLKS) begin
            rx_sh_q <= {rx_sh_q[6:0], i_sda};
         end
         if (cnt_q == mg_pkg::LEAD_CLKS - 4'h1) begin
            // Fresh answer only when its toggle has crossed
            tx_sh_q <= (ack_s2_q != ack_seen_q) ? xfer.tx_data : mg_pkg::IDLE_BYTE;
            drive_q <= (ack_s2_q != ack_seen_q) & xfer.tx_drive;
         end else if (cnt_q == mg_pkg::LAST_CLK) begin
            drive_q <= 1'b0;
         end else if (cnt_q >= mg_pkg::LEAD_CLKS) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b1};
         end
      end
   end

   // Answer toggle synchroniser and byte hand-off
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_seen_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_tgl_q <= 1'b0;
      end else begin
         ack_s1_q <= xfer.tx_tgl;
         ack_s2_q <= ack_s1_q;
         if (!i_sel_n && cnt_q == mg_pkg::LEAD_CLKS - 4'h1) begin
            ack_seen_q <= ack_s2_q;
         end
         // (R20) Whole byte passed on
         if (!i_sel_n && cnt_q == mg_pkg::LAST_CLK) begin
            rx_data_q <= {rx_sh_q[6:0], i_sda};
            rx_tgl_q <= ~rx_tgl_q;
         end
      end
   end

   assign xfer.rx_data = rx_data_q;
   assign xfer.rx_tgl = rx_tgl_q;
   assign o_sda = tx_sh_q[7];
   assign o_sda_oe_n = ~drive_q;
endmodule
`default_nettype wire

// *** rtl/mg_cmd_responder.sv ***
/*
 Command responder for the serial management bus: status, capability,
 temperature, revision and identity reads, and paged memory access.
 Assumes temperatures, download checksum and fault pulse come from
 logic on i_clk; the link clock is unrelated to i_clk.
*/
`default_nettype none
// Summary of operation
// (R1) Capability bit 7 reads zero
// (R2) Capability speed field reads 01
// (R3) Capability alert bit reads zero
// (R4) Capability read returns 0x20
// (R5) Status byte equals status word low byte
// (R6) One means fault, zero none
// (R7) Fault bit one set on faults
// (R8) Other status bits always read zero
// (R9) Temperature commands return sensor words
// (R10) Exponent in 15:11, mantissa below
// (R11) Protocol revision read returns 0x11
// (R12) Identity bytes are read only
// (R13) Pages all readable, writes pages 4-15
// (R14) Page index is command minus first
// (R15) Checksum command returns download checksum
// (R16) Read length register sets block size
// (R17) Offset register selects page start byte
// (R18) Clear command clears fault bits
// (R19) Reserved zero; read-only writes flag fault
// (R20) Low byte first; reads advance offset
module mg_cmd_responder #(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] MODEL_CODE = 8'h3c, // Arbitrary value
   parameter logic [7:0] MAKER_VER = 8'h01 // Arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_link_clk,
   input wire logic i_sel_n,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input wire logic [15:0] i_temp_one,
   input wire logic [15:0] i_temp_two,
   input wire logic [7:0] i_download_crc,
   input wire logic i_mem_fault,
   output logic o_cml_fault
);
   typedef enum logic [1:0] {ST_IDLE, ST_OP, ST_CMD, ST_DATA} state_t;

   mg_xfer_if xfer ();

   // Serial side on the link clock
   mg_link_shifter u_link (
      .i_link_clk(i_link_clk),
      .i_rst(i_rst),
      .i_sel_n(i_sel_n),
      .i_sda(i_sda),
      .o_sda(o_sda),
      .o_sda_oe_n(o_sda_oe_n),
      .xfer(xfer.link)
   );

   logic sel_s1_q; // Select, stage one
   logic sel_s2_q; // Select, stage two
   logic frame_q; // Frame seen last cycle
   logic frame_now; // Frame active now
   logic frame_start; // Frame begins
   logic frame_end; // Frame ends
   logic rx_s1_q; // Byte toggle, stage one
   logic rx_s2_q; // Byte toggle, stage two
   logic rx_seen_q; // Last toggle handled
   logic rx_evt; // New byte this cycle
   logic [7:0] rx_byte; // Byte from link
   state_t state_q; // Frame position
   logic op_read_q; // Frame is a read
   logic [7:0] cmd_q; // Command code
   logic [7:0] idx_q; // Data byte index
   logic [7:0] buf_lo_q; // First data byte
   logic [7:0] buf_hi_q; // Second data byte
   logic [7:0] rdlen_q; // Block read length
   logic [15:0] ofs_q; // Page start offset
   logic cml_q; // Comms/memory/logic fault
   logic cml_d;
   logic [7:0] tx_data_q; // Answer byte
   logic tx_drive_q; // Answer is driven
   logic tx_tgl_q; // Answer toggle
   logic [7:0] cap_value; // Capability byte
   logic [15:0] fault_word; // Status word
   logic in_data; // In data phase
   logic commit; // Frame closed in data phase
   logic page_wr; // Data byte for a page
   logic page_ok; // Page may be written
   logic mem_we; // Memory write strobe
   logic [8:0] mem_wa; // Memory write address
   logic comm_err; // Protocol fault this cycle
   logic [7:0] nvm_q [mg_pkg::NVM_WORDS]; // Page memory

   // True for the sixteen page commands
   function automatic logic is_page(input logic [7:0] c);
      return c >= mg_pkg::CMD_PG_FIRST && c <= mg_pkg::CMD_PG_LAST;
   endfunction

   // True for a command that accepts data
   function automatic logic is_writable(input logic [7:0] c);
      return c == mg_pkg::CMD_RDLEN || c == mg_pkg::CMD_OFS || is_page(c);
   endfunction

   // True for any command this block answers
   function automatic logic is_known(input logic [7:0] c);
      unique case (c)
         mg_pkg::CMD_CLEAR, mg_pkg::CMD_CAP, mg_pkg::CMD_FSB,
         mg_pkg::CMD_FSW, mg_pkg::CMD_TMP1, mg_pkg::CMD_TMP2,
         mg_pkg::CMD_PROTO, mg_pkg::CMD_MAKER, mg_pkg::CMD_MODEL,
         mg_pkg::CMD_MVER, mg_pkg::CMD_CRC, mg_pkg::CMD_RDLEN,
         mg_pkg::CMD_OFS: return 1'b1;
         default: return is_page(c);
      endcase
   endfunction

   // Byte k of a 16-bit value, low byte first
   function automatic logic [7:0] word_byte(input logic [15:0] w,
                                            input logic [7:0] k);
      return (k == 8'h00) ? w[7:0] : w[15:8];
   endfunction

   // Page address for data byte k of command c
   function automatic logic [8:0] page_addr(input logic [7:0] c,
                                            input logic [7:0] k);
      logic [4:0] col;
      col = ofs_q[mg_pkg::PG_AW-1:0] + 5'(k - 8'h01);
      return {c[3:0], col};
   endfunction

   // Answer byte k of a read of command c
   function automatic logic [7:0] read_byte(input logic [7:0] c,
                                            input logic [7:0] k);
      logic [7:0] r;
      r = mg_pkg::IDLE_BYTE;
      if (is_page(c)) begin
         // Count byte first, then bytes from the offset onward
         if (k == 8'h00) begin
            r = rdlen_q;
         end else if (k <= rdlen_q) begin
            r = nvm_q[page_addr(c, k)];
         end
      end else begin
         unique case (c)
            mg_pkg::CMD_CAP: r = cap_value;
            mg_pkg::CMD_FSB: r = fault_word[7:0];
            mg_pkg::CMD_FSW: r = word_byte(fault_word, k);
            // (R9) (R10) Sensor words pass whole
            mg_pkg::CMD_TMP1: r = word_byte(i_temp_one, k);
            mg_pkg::CMD_TMP2: r = word_byte(i_temp_two, k);
            mg_pkg::CMD_PROTO: r = mg_pkg::PROTO_RESET;
            // (R12) Fixed identity bytes
            mg_pkg::CMD_MAKER: r = MAKER_CODE;
            mg_pkg::CMD_MODEL: r = MODEL_CODE;
            mg_pkg::CMD_MVER: r = MAKER_VER;
            // (R15) Checksum passes through
            mg_pkg::CMD_CRC: r = i_download_crc;
            mg_pkg::CMD_RDLEN: r = rdlen_q;
            mg_pkg::CMD_OFS: r = word_byte(ofs_q, k);
            default: r = mg_pkg::IDLE_BYTE;
         endcase
      end
      return r;
   endfunction

   // (R1) No error checking bit; (R3) no alert bit
   // (R2) Fixed speed field
   // (R19) Reserved low bits zero
   assign cap_value = {1'b0, mg_pkg::CAP_SPEED, 1'b0, 4'h0};

   // (R8) Only the fault bit can be one
   // (R6) One means a fault was seen
   assign fault_word = 16'(cml_q) << mg_pkg::FSW_CML_BIT;

   // Select and byte toggle enter this clock domain
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_s1_q <= 1'b1;
         sel_s2_q <= 1'b1;
         frame_q <= 1'b0;
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rx_seen_q <= 1'b0;
      end else begin
         sel_s1_q <= i_sel_n;
         sel_s2_q <= sel_s1_q;
         frame_q <= frame_now;
         rx_s1_q <= xfer.rx_tgl;
         rx_s2_q <= rx_s1_q;
         rx_seen_q <= rx_s2_q;
      end
   end

   assign frame_now = ~sel_s2_q;
   assign frame_start = frame_now & ~frame_q;
   assign frame_end = ~frame_now & frame_q;
   assign rx_evt = rx_s2_q ^ rx_seen_q;
   // Stable: held by the shifter for a whole byte time
   assign rx_byte = xfer.rx_data;
   assign in_data = state_q == ST_DATA;
   assign commit = frame_end & in_data;

   // Frame sequencer: operation, command, data bytes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         op_read_q <= 1'b0;
         cmd_q <= 8'h00;
         idx_q <= 8'h00;
         buf_lo_q <= 8'h00;
         buf_hi_q <= 8'h00;
      end else if (frame_start) begin
         state_q <= ST_OP;
         idx_q <= 8'h00;
      end else if (frame_end) begin
         state_q <= ST_IDLE;
      end else if (rx_evt) begin
         unique case (state_q)
            ST_IDLE: state_q <= ST_IDLE;
            ST_OP: begin
               op_read_q <= rx_byte == mg_pkg::OP_READ;
               state_q <= ST_CMD;
            end
            ST_CMD: begin
               cmd_q <= rx_byte;
               idx_q <= 8'h00;
               state_q <= ST_DATA;
            end
            ST_DATA: begin
               // Index saturates on over-long frames
               if (idx_q != 8'hff) begin
                  idx_q <= idx_q + 8'h01;
               end
               if (idx_q == 8'h00) begin
                  buf_lo_q <= rx_byte;
               end
               if (idx_q == 8'h01) begin
                  buf_hi_q <= rx_byte;
               end
            end
         endcase
      end
   end

   // Answer for the next byte the host clocks
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_data_q <= mg_pkg::IDLE_BYTE;
         tx_drive_q <= 1'b0;
         tx_tgl_q <= 1'b0;
      end else if (rx_evt) begin
         tx_tgl_q <= ~tx_tgl_q;
         if (state_q == ST_CMD && op_read_q) begin
            tx_data_q <= read_byte(rx_byte, 8'h00);
            tx_drive_q <= 1'b1;
         end else if (in_data && op_read_q) begin
            // (R20) Next byte of the same command
            tx_data_q <= read_byte(cmd_q, idx_q + 8'h01);
            tx_drive_q <= 1'b1;
         end else begin
            tx_data_q <= mg_pkg::IDLE_BYTE;
            tx_drive_q <= 1'b0;
         end
      end else if (frame_start) begin
         // Last read's spare answer must not fight the host's operation byte
         tx_data_q <= mg_pkg::IDLE_BYTE;
         tx_drive_q <= 1'b0;
      end
   end

   assign xfer.tx_data = tx_data_q;
   assign xfer.tx_drive = tx_drive_q;
   assign xfer.tx_tgl = tx_tgl_q;

   // Writable settings, taken when the frame closes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdlen_q <= mg_pkg::RDLEN_RESET;
         ofs_q <= mg_pkg::OFS_RESET;
      end else if (commit && !op_read_q) begin
         // (R16) One byte sets the block read size
         if (cmd_q == mg_pkg::CMD_RDLEN && idx_q != 8'h00) begin
            rdlen_q <= buf_lo_q;
         end
         // (R17) Offset arrives low byte first
         if (cmd_q == mg_pkg::CMD_OFS && idx_q >= 8'h02) begin
            ofs_q <= {buf_hi_q, buf_lo_q};
         end
      end
   end

   // Page data bytes follow the count byte
   assign page_wr = rx_evt & in_data & ~op_read_q & is_page(cmd_q) & (idx_q != 8'h00);
   // (R13) Low pages 0-3 have no reset value and are never written
   assign page_ok = cmd_q[3:0] >= mg_pkg::PG_WR_MIN;
   assign mem_we = page_wr & page_ok;
   // (R14) Page from command; (R20) column advances per byte
   assign mem_wa = page_addr(cmd_q, idx_q);

   // Page memory, no reset; contents come from the host
   always_ff @(posedge i_clk) begin
      if (mem_we) begin
         nvm_q[mem_wa] <= rx_byte;
      end
   end

   // (R19) Protocol faults: short frame, unknown or read-only target
   always_comb begin
      comm_err = 1'b0;
      if (frame_end && (state_q == ST_OP || state_q == ST_CMD)) begin
         comm_err = 1'b1;
      end
      if (commit && !is_known(cmd_q)) begin
         comm_err = 1'b1;
      end
      if (commit && !op_read_q && idx_q != 8'h00 && !is_writable(cmd_q)) begin
         comm_err = 1'b1;
      end
      if (commit && op_read_q && cmd_q == mg_pkg::CMD_CLEAR) begin
         comm_err = 1'b1;
      end
      // (R13) Refused page write
      if (page_wr && !page_ok) begin
         comm_err = 1'b1;
      end
   end

   // (R7) Set wins over clear; (R18) clear on bare clear command
   always_comb begin
      cml_d = cml_q;
      if (commit && !op_read_q && cmd_q == mg_pkg::CMD_CLEAR && idx_q == 8'h00) begin
         cml_d = 1'b0;
      end
      if (i_mem_fault || comm_err) begin
         cml_d = 1'b1;
      end
   end

   // Fault flag
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cml_q <= 1'b0;
      end else begin
         cml_q <= cml_d;
      end
   end

   assign o_cml_fault = cml_q;

   // Checks on the system clock
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic read_cmd_evt; // Command byte of a read frame
   assign read_cmd_evt = rx_evt & (state_q == ST_CMD) & op_read_q;

   property p_cap_reply;
      read_cmd_evt && rx_byte == mg_pkg::CMD_CAP |=>
         tx_data_q == mg_pkg::CAP_RESET && tx_drive_q && $changed(tx_tgl_q);
   endproperty
   a_cap_reply: assert property (p_cap_reply) else $error("bad capability answer"); // R4

   property p_cap_fields;
      read_cmd_evt && rx_byte == mg_pkg::CMD_CAP |=> tx_data_q[7] == 1'b0
         && tx_data_q[4] == 1'b0 && tx_data_q[6:5] == 2'h1 && tx_data_q[3:0] == 4'h0;
   endproperty
   a_cap_fields: assert property (p_cap_fields) else $error("bad capability bits"); // R2

   property p_status_byte;
      read_cmd_evt && rx_byte == mg_pkg::CMD_FSB |=> tx_data_q == {6'h00, $past(cml_q), 1'b0};
   endproperty
   a_status_byte: assert property (p_status_byte) else $error("bad status byte"); // R5

   property p_status_zero;
      fault_word[15:2] == 14'h0000 && fault_word[0] == 1'b0 && fault_word[1] == cml_q;
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("bad status word"); // R8

   property p_fault_set;
      i_mem_fault |=> cml_q ##1 (cml_q || $past(commit));
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not held"); // R7

   property p_clear;
      commit && !op_read_q && cmd_q == mg_pkg::CMD_CLEAR && idx_q == 8'h00
         && !i_mem_fault |=> !cml_q;
   endproperty
   a_clear: assert property (p_clear) else $error("fault not cleared"); // R18

   property p_temp_hi;
      rx_evt && in_data && op_read_q && cmd_q == mg_pkg::CMD_TMP1 && idx_q == 8'h00
         |=> tx_data_q == $past(i_temp_one[15:8]);
   endproperty
   a_temp_hi: assert property (p_temp_hi) else $error("bad temperature byte"); // R9

   property p_proto;
      read_cmd_evt && rx_byte == mg_pkg::CMD_PROTO |=> tx_data_q == 8'h11;
   endproperty
   a_proto: assert property (p_proto) else $error("bad revision answer"); // R11

   property p_page_guard;
      mem_we |-> cmd_q[3:0] >= 4'h4 && mem_wa[8:5] == cmd_q[3:0];
   endproperty
   a_page_guard: assert property (p_page_guard) else $error("write to locked page"); // R13

   property p_rdlen;
      commit && !op_read_q && cmd_q == mg_pkg::CMD_RDLEN && idx_q == 8'h01
         |=> rdlen_q == $past(buf_lo_q) ##1 $stable(rdlen_q);
   endproperty
   a_rdlen: assert property (p_rdlen) else $error("read length not taken"); // R16

   property p_answer;
      rx_evt |=> $changed(tx_tgl_q) ##1 $stable(tx_tgl_q);
   endproperty
   a_answer: assert property (p_answer) else $error("no answer to byte"); // R20

   c_cap_read: cover property (read_cmd_evt && rx_byte == mg_pkg::CMD_CAP);
   c_page_write: cover property (mem_we ##[1:40] mem_we);
   c_clear: cover property (cml_q ##[1:400] !cml_q);
endmodule
`default_nettype wire

// *** sim/mg_host_model.sv ***
/*
 Host controller model for the management link: frames of 10-clock bytes.
 Assumes the bench resolves the data wire with a pull-up.
*/
`default_nettype none
module mg_host_model (
   output logic o_link_clk,
   output logic o_sel_n,
   output logic o_drv,
   output logic o_bit,
   input wire logic i_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rd [0:7]; // Answer bytes of the last frame
   // Idle: clock stands still, frame closed, wire released
   initial begin
      o_link_clk = 1'b0;
      o_sel_n = 1'b1;
      o_drv = 1'b0;
      o_bit = 1'b1;
   end
   // One byte, msb first on clocks 2..9; sample before each rising edge
   task automatic xbyte(input logic [7:0] wb, input logic drv, output logic [7:0] rb);
      for (int c = 0; c < 10; c++) begin
         o_drv = drv && c > 1;
         if (c > 1)
            o_bit = wb[9-c];
         #6;
         if (c > 1)
            rb = {rb[6:0], i_wire};
         o_link_clk = 1'b1;
         #6;
         o_link_clk = 1'b0;
      end
      // Release, so the pull-up owns the wire
      o_drv = 1'b0;
      // Long gap lets the answer cross domains
      #200;
   endtask
   // Whole frame: operation, command, nw bytes low first, nr answers
   task automatic frame(input logic [7:0] op, cmd, input int nw, input logic [63:0] wd,
                        input int nr);
      logic [7:0] t;
      o_sel_n = 1'b0;
      #200;
      xbyte(op, 1'b1, t);
      xbyte(cmd, 1'b1, t);
      for (int k = 0; k < nw; k++)
         xbyte(wd[8*k+:8], 1'b1, t);
      for (int k = 0; k < nr; k++)
         xbyte(8'hff, 1'b0, rd[k]);
      #200;
      o_sel_n = 1'b1;
      // Frame spacing; registers settle meanwhile
      #300;
   endtask
endmodule
`default_nettype wire

// *** sim/mg_cmd_responder_tb.sv ***
/*
 Self-checking bench for the management command responder.
 Assumes the host model drives the link and the data wire pulls up.
*/
`default_nettype none
module mg_cmd_responder_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
   localparam logic [7:0] MK = 8'h6e; // Arbitrary value
   localparam logic [7:0] MD = 8'h27; // Arbitrary value
   localparam logic [7:0] MV = 8'h03; // Arbitrary value
   int err_count = 0;
   int n_checks = 0;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] temp_one = 16'h0000;
   logic [15:0] temp_two = 16'h0000;
   logic [7:0] crc = 8'h00;
   logic mem_fault = 1'b0;
   logic link_clk, sel_n, host_drv, host_bit, dev_sda, dev_oe_n, cml, sda_wire;
   // Wire level: device, else host, else pull-up
   assign sda_wire = !dev_oe_n ? dev_sda : (host_drv ? host_bit : 1'b1);
   // System clock, 100 MHz
   always #5 clk = ~clk;
   mg_cmd_responder #(.MAKER_CODE(MK), .MODEL_CODE(MD), .MAKER_VER(MV)) mg_cmd_responder_i (
      .i_clk(clk), .i_rst(rst), .i_link_clk(link_clk), .i_sel_n(sel_n), .i_sda(sda_wire),
      .o_sda(dev_sda), .o_sda_oe_n(dev_oe_n), .i_temp_one(temp_one),
      .i_temp_two(temp_two), .i_download_crc(crc), .i_mem_fault(mem_fault),
      .o_cml_fault(cml));
   mg_host_model mg_host_model_i (.o_link_clk(link_clk), .o_sel_n(sel_n), .o_drv(host_drv),
      .o_bit(host_bit), .i_wire(sda_wire));
   // Read n bytes, low byte first, and compare
   task automatic rd_chk(input logic [7:0] cmd, input int n, input logic [15:0] e);
      mg_host_model_i.frame(mg_pkg::OP_READ, cmd, 0, '0, n);
      `CHK(n == 2 ? {mg_host_model_i.rd[1], mg_host_model_i.rd[0]}
           : {8'h00, mg_host_model_i.rd[0]}, e)
   endtask
   // Write frame with any non-read operation byte
   task automatic wr(input logic [7:0] cmd, input int n, input logic [63:0] d);
      mg_host_model_i.frame(8'h00, cmd, n, d, 0);
   endtask
   // Page read: count byte, three data bytes, then filler
   task automatic pg_chk(input logic [7:0] cmd, input logic [23:0] d);
      mg_host_model_i.frame(mg_pkg::OP_READ, cmd, 0, '0, 5);
      `CHK(mg_host_model_i.rd[0], 8'h03)
      `CHK({mg_host_model_i.rd[3], mg_host_model_i.rd[2], mg_host_model_i.rd[1]}, d)
      `CHK(mg_host_model_i.rd[4], 8'hff)
   endtask
   // Fixed and identity reads; a write to read-only flags a fault
   task automatic t_ident();
      rd_chk(8'h19, 1, 16'h0020);
      rd_chk(8'h98, 1, 16'h0011);
      rd_chk(8'h99, 1, {8'h00, MK});
      rd_chk(8'h9a, 1, {8'h00, MD});
      rd_chk(8'h9b, 1, {8'h00, MV});
      wr(8'h99, 1, 64'h55);
      `CHK(cml, 1'b1)
      rd_chk(8'h99, 1, {8'h00, MK});
      wr(8'h03, 0, '0);
   endtask
   // Pass-through words, sign bit and exponent set on purpose
   task automatic t_temps();
      @(posedge clk);
      temp_one <= 16'hd3a5;
      temp_two <= 16'h1c42;
      crc <= 8'h9e;
      rd_chk(8'h8d, 2, 16'hd3a5);
      rd_chk(8'h8e, 2, 16'h1c42);
      rd_chk(8'hd1, 1, 16'h009e);
   endtask
   // Fault flag set by a pulse, seen in both reads, cleared by command
   task automatic t_status();
      rd_chk(8'h78, 1, 16'h0000);
      @(posedge clk);
      mem_fault <= 1'b1;
      @(posedge clk);
      mem_fault <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(cml, 1'b1)
      rd_chk(8'h78, 1, 16'h0002);
      rd_chk(8'h79, 2, 16'h0002);
      wr(8'h03, 0, '0);
      `CHK(cml, 1'b0)
      rd_chk(8'h79, 2, 16'h0000);
   endtask
   // Length, offset and paged memory, lowest and highest writable page
   task automatic t_nvm();
      wr(8'hd2, 1, 64'h03);
      rd_chk(8'hd2, 1, 16'h0003);
      wr(8'hd3, 2, 64'h0105);
      rd_chk(8'hd3, 2, 16'h0105);
      wr(8'hd3, 2, 64'h0005);
      // Host keeps to pages 4..15 here
      wr(8'hb4, 4, 64'hc3b2a103);
      wr(8'hbf, 4, 64'h6f5e4d03);
      `CHK(cml, 1'b0)
      pg_chk(8'hb4, 24'hc3b2a1);
      pg_chk(8'hbf, 24'h6f5e4d);
      // Deliberate write to a protected page
      wr(8'hb0, 2, 64'h7703);
      `CHK(cml, 1'b1)
      wr(8'h03, 0, '0);
   endtask
   // Counts, then the verdict, then stop
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence; reset held eight cycles
   initial begin
      repeat (8) @(posedge clk);
      `CHK(cml, 1'b0)
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_ident();
      t_temps();
      t_status();
      t_nvm();
      wrap_up();
   end
   // Watchdog, well above the ~51 us the frames need
   initial begin
      #500000;
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
